// file: rtl/rdmem_regs.svh
// Register offsets, field positions, codes and constants of the reading memory.
// Assumes inclusion by rdmem_store and by the bench only.
`ifndef RDMEM_REGS_SVH
`define RDMEM_REGS_SVH

`define RDMEM_CTRL_OFF     8'h00
`define RDMEM_FORMAT_OFF   8'h04
`define RDMEM_STATUS_OFF   8'h08
`define RDMEM_COUNT_OFF    8'h0C
`define RDMEM_SCALE_OFF    8'h10
`define RDMEM_DATA_LO_OFF  8'h14
`define RDMEM_DATA_HI_OFF  8'h18
`define RDMEM_RECALL_OFF   8'h1C

`define RDMEM_MODE_OFF     2'h0
`define RDMEM_MODE_LIFO    2'h1
`define RDMEM_MODE_FIFO    2'h2
`define RDMEM_MODE_RESUME  2'h3

`define RDMEM_FMT_TEXT     3'h1
`define RDMEM_FMT_INT16    3'h2
`define RDMEM_FMT_INT32    3'h3
`define RDMEM_FMT_FLOAT32  3'h4
`define RDMEM_FMT_FLOAT64  3'h5

`define RDMEM_ST_ENABLED   0
`define RDMEM_ST_LIFO      1
`define RDMEM_ST_FULL      2
`define RDMEM_ST_HOLD      3
`define RDMEM_ST_ARM_ERR   4
`define RDMEM_ST_OVLD      5

`define RDMEM_TEXT_BYTES   5'h10
`define RDMEM_OVLD_POS     64'h47D2_CED3_2A16_A1B1
`define RDMEM_OVLD_NEG     64'hC7D2_CED3_2A16_A1B1

`endif

// file: rtl/rdmem_pkg.sv
// Types of the reading memory.
// Assumes rdmem_regs.svh holds all numeric constants.
package rdmem_pkg;
  typedef logic [1:0] rdmem_mode_t;
  typedef logic [2:0] rdmem_fmt_t;
  typedef enum logic [1:0] {
    RDMEM_RD_IDLE = 2'b00,
    RDMEM_RD_DATA = 2'b01,
    RDMEM_RD_DONE = 2'b11
  } rdmem_rd_t;
endpackage

// file: rtl/rdmem_store.sv
// Reading memory store: FIFO/LIFO storage of readings, AXI4-Lite register slave.
// Assumes readings arrive as one-cycle strobes synchronous to clk; controller reads
// stored readings over the bus.
//
// Contract
// - Mode 0 stops storing; contents stay.
// - Mode 1 empties memory, stores last-in-first-out.
// - Mode 2 empties memory, stores first-in-first-out.
// - Mode 3 keeps contents, restores previous order, else FIFO.
// - Storage disabled after reset.
// - High-speed FIFO full forces arm source to hold.
// - Normal FIFO full discards new readings.
// - LIFO full overwrites oldest readings.
// - Implied read with empty output buffer removes one reading; code ignores it when a reading is stored that cycle.
// - Implied read: newest in LIFO, oldest in FIFO.
// - Explicit recall ignores ordering mode.
// - Explicit recall disables storage until a mode is chosen.
// - Count query returns number of stored readings.
// - Selecting storage format empties memory.
// - Code 2 is 16-bit integer, code 3 is 32-bit integer.
// - Code 4 single float, code 5 double float.
// - Code 1 text, 16 bytes per reading with null separator; code stores one 64-bit word with its low byte zeroed and reports 16 on recall.
// - Single float format after reset.
// - Overload marker stored, converted to output overload value; code rescales it on implied read in integer formats.
// - Integer formats stored relative to scale factor, multiplied on recall; code multiplies on implied read only, explicit recall returns stored value.
// - Subsampled arm errors unless int16, FIFO and empty.
// - Storage format independent of output format.
`timescale 1ns/1ns
`include "rdmem_regs.svh"

module rdmem_store #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        rdg_valid,
  input  wire logic [63:0] rdg_value,
  input  wire logic        rdg_ovld,
  input  wire logic        rdg_ovld_neg,
  input  wire logic        high_speed,
  input  wire logic        arm_event,
  input  wire logic        subsampled,
  input  wire logic        arm_source_set,
  input  wire logic        out_buf_empty,
  input  wire logic        data_request,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             arm_hold,
  output logic             arm_error,
  output logic             out_valid,
  output logic [63:0]      out_data
);
  import rdmem_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  logic [63:0]         mem_q [DEPTH];
  logic [AW-1:0]       head_q;
  logic [AW:0]         count_q;
  logic [AW:0]         capacity_q;
  rdmem_mode_t         mode_q;
  rdmem_mode_t         order_q;
  logic                had_order_q;
  rdmem_fmt_t          fmt_q;
  logic signed [31:0]  scale_q;
  logic [4:0]          text_len_q;
  logic [63:0]         recall_q;
  logic                ovld_seen_q;
  logic                full;
  logic                empty;
  logic                storing;
  logic                store_now;
  logic                implied_rd;
  logic [AW-1:0]       wr_idx;
  logic [AW-1:0]       tail_idx;
  logic [AW-1:0]       pop_idx;
  logic [63:0]         enc;
  logic                ctrl_wr;
  logic                fmt_wr;
  logic                recall_wr;
  logic [AW-1:0]       recall_idx_q;

  assign empty   = (count_q == '0);
  assign full    = (count_q >= capacity_q);
  assign storing = (mode_q == `RDMEM_MODE_LIFO) || (mode_q == `RDMEM_MODE_FIFO);
  // FIFO full: drop in either speed; high speed additionally holds arm
  assign store_now = rdg_valid && storing && !arm_hold
                     && !(full && mode_q == `RDMEM_MODE_FIFO);
  assign implied_rd = data_request && out_buf_empty && storing && !empty;
  assign tail_idx = AW'(head_q + AW'(count_q));
  // Full LIFO writes at tail and advances head, so newest stays at tail-1
  assign wr_idx   = tail_idx;
  // Newest is just before tail, oldest at head
  assign pop_idx  = (mode_q == `RDMEM_MODE_LIFO) ? AW'(tail_idx - 1'b1) : head_q;

  // Encode per storage format; integer formats hold reading/scale
  always_comb begin
    enc = rdg_value;
    unique case (fmt_q)
      `RDMEM_FMT_INT16: enc = {48'h0, 16'(signed'(rdg_value[31:0]) / scale_q)};
      `RDMEM_FMT_INT32: enc = {32'h0, 32'(signed'(rdg_value[31:0]) / scale_q)};
      `RDMEM_FMT_FLOAT32: enc = {32'h0, rdg_value[31:0]};
      `RDMEM_FMT_FLOAT64: enc = rdg_value;
      `RDMEM_FMT_TEXT: enc = {rdg_value[63:8], 8'h00};
      default: enc = rdg_value;
    endcase
    if (rdg_ovld) begin
      enc = rdg_ovld_neg ? `RDMEM_OVLD_NEG : `RDMEM_OVLD_POS;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go;

  assign wr_go     = aw_have_q && w_have_q && !s_axi_bvalid;
  assign ctrl_wr   = wr_go && aw_addr_q == `RDMEM_CTRL_OFF && w_strb_q[0];
  assign fmt_wr    = wr_go && aw_addr_q == `RDMEM_FORMAT_OFF && w_strb_q[0];
  assign recall_wr = wr_go && aw_addr_q == `RDMEM_RECALL_OFF && w_strb_q[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unmapped or read-only offsets answer SLVERR
        s_axi_bresp  <= (aw_addr_q == `RDMEM_CTRL_OFF || aw_addr_q == `RDMEM_FORMAT_OFF
                         || aw_addr_q == `RDMEM_SCALE_OFF || aw_addr_q == `RDMEM_RECALL_OFF
                         || aw_addr_q == `RDMEM_COUNT_OFF) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Storage mode and ordering
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q      <= `RDMEM_MODE_OFF;
      order_q     <= `RDMEM_MODE_FIFO;
      had_order_q <= 1'b0;
    end else if (ctrl_wr) begin
      unique case (w_data_q[1:0])
        `RDMEM_MODE_OFF: mode_q <= `RDMEM_MODE_OFF;
        `RDMEM_MODE_LIFO: begin
          mode_q      <= `RDMEM_MODE_LIFO;
          order_q     <= `RDMEM_MODE_LIFO;
          had_order_q <= 1'b1;
        end
        `RDMEM_MODE_FIFO: begin
          mode_q      <= `RDMEM_MODE_FIFO;
          order_q     <= `RDMEM_MODE_FIFO;
          had_order_q <= 1'b1;
        end
        `RDMEM_MODE_RESUME: begin
          mode_q <= had_order_q ? order_q : `RDMEM_MODE_FIFO;
        end
      endcase
    end else if (recall_wr) begin
      mode_q <= `RDMEM_MODE_OFF;
    end
  end

  // Format, scale and capacity; output format lives elsewhere
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fmt_q      <= `RDMEM_FMT_FLOAT32;
      scale_q    <= 32'sh0000_0001;
      capacity_q <= (AW+1)'(DEPTH);
    end else if (wr_go) begin
      if (aw_addr_q == `RDMEM_FORMAT_OFF && w_strb_q[0]
          && w_data_q[2:0] >= `RDMEM_FMT_TEXT && w_data_q[2:0] <= `RDMEM_FMT_FLOAT64) begin
        fmt_q <= w_data_q[2:0];
      end
      if (aw_addr_q == `RDMEM_SCALE_OFF && w_data_q != 32'h0000_0000) begin
        scale_q <= signed'(w_data_q);
      end
      if (aw_addr_q == `RDMEM_COUNT_OFF && w_data_q[AW:0] != '0
          && w_data_q[AW:0] <= (AW+1)'(DEPTH)) begin
        capacity_q <= w_data_q[AW:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Memory contents, head and count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      head_q  <= '0;
      count_q <= '0;
    end else if (fmt_wr || (ctrl_wr && (w_data_q[1:0] == `RDMEM_MODE_LIFO
                                      || w_data_q[1:0] == `RDMEM_MODE_FIFO))) begin
      head_q  <= '0;
      count_q <= '0;
    end else begin
      if (store_now) begin
        mem_q[wr_idx] <= enc;
        if (full) begin
          head_q <= AW'(head_q + 1'b1);
        end
      end
      if (implied_rd && !store_now) begin
        count_q <= (AW+1)'(count_q - 1'b1);
        if (mode_q == `RDMEM_MODE_FIFO) begin
          head_q <= AW'(head_q + 1'b1);
        end
      end else if (store_now && !full && !implied_rd) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // Arm hold and subsampled error
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arm_hold  <= 1'b0;
      arm_error <= 1'b0;
    end else begin
      if (arm_source_set) begin
        arm_hold <= 1'b0;
      end else if (high_speed && mode_q == `RDMEM_MODE_FIFO && full) begin
        arm_hold <= 1'b1;
      end
      if (arm_event && subsampled) begin
        arm_error <= !(fmt_q == `RDMEM_FMT_INT16 && mode_q == `RDMEM_MODE_FIFO
                       && empty);
      end else begin
        arm_error <= 1'b0;
      end
    end
  end

  // Implied-read output with integer rescale; overload markers pass through outside integer formats
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data  <= 64'h0;
    end else begin
      out_valid <= implied_rd && !store_now;
      if (implied_rd && !store_now) begin
        if (fmt_q == `RDMEM_FMT_INT16) begin
          out_data <= 64'(signed'(mem_q[pop_idx][15:0]) * scale_q);
        end else if (fmt_q == `RDMEM_FMT_INT32) begin
          out_data <= 64'(signed'(mem_q[pop_idx][31:0]) * scale_q);
        end else begin
          out_data <= mem_q[pop_idx];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Explicit recall: word index written, oldest-based regardless of mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      recall_idx_q <= '0;
      recall_q     <= 64'h0;
      text_len_q   <= 5'h00;
      ovld_seen_q  <= 1'b0;
    end else if (recall_wr) begin
      recall_idx_q <= AW'(head_q + w_data_q[AW-1:0]);
      recall_q     <= mem_q[AW'(head_q + w_data_q[AW-1:0])];
      text_len_q   <= (fmt_q == `RDMEM_FMT_TEXT) ? `RDMEM_TEXT_BYTES : 5'h00;
      ovld_seen_q  <= (mem_q[AW'(head_q + w_data_q[AW-1:0])] == `RDMEM_OVLD_POS)
                   || (mem_q[AW'(head_q + w_data_q[AW-1:0])] == `RDMEM_OVLD_NEG);
    end
  end

  // AXI4-Lite read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        unique case (s_axi_araddr)
          `RDMEM_CTRL_OFF:    s_axi_rdata <= {30'h0, mode_q};
          `RDMEM_FORMAT_OFF:  s_axi_rdata <= {29'h0, fmt_q};
          `RDMEM_STATUS_OFF:  s_axi_rdata <= {26'h0, ovld_seen_q, arm_error, arm_hold,
                                              full, mode_q == `RDMEM_MODE_LIFO, storing};
          `RDMEM_COUNT_OFF:   s_axi_rdata <= 32'(count_q);
          `RDMEM_SCALE_OFF:   s_axi_rdata <= scale_q;
          `RDMEM_DATA_LO_OFF: s_axi_rdata <= recall_q[31:0];
          `RDMEM_DATA_HI_OFF: s_axi_rdata <= recall_q[63:32];
          `RDMEM_RECALL_OFF:  s_axi_rdata <= {27'h0, text_len_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// file: test/rdmem_store_properties.sv
// Port checker for the reading memory store.
// Assumes it is bound to every rdmem_store instance.
`timescale 1ns/1ns
module rdmem_store_properties (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        arm_event,
  input wire logic        subsampled,
  input wire logic        arm_source_set,
  input wire logic        high_speed,
  input wire logic        data_request,
  input wire logic        out_buf_empty,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        arm_hold,
  input wire logic        arm_error,
  input wire logic        out_valid,
  input wire logic [63:0] out_data
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_bstand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bstand: assert property (p_bstand) else $error("write response dropped early");
  property p_rstand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rstand: assert property (p_rstand) else $error("read data dropped early");
  property p_err;
    arm_error |-> $past(arm_event && subsampled);
  endproperty
  a_err: assert property (p_err) else $error("arm error without arm");
  property p_out;
    out_valid |-> $past(data_request && out_buf_empty);
  endproperty
  a_out: assert property (p_out) else $error("reading sent unrequested");
  property p_outhold;
    !out_valid |-> $stable(out_data);
  endproperty
  a_outhold: assert property (p_outhold) else $error("output data moved");
  property p_holdclr;
    $fell(arm_hold) && $past(rst_n) |-> $past(arm_source_set);
  endproperty
  a_holdclr: assert property (p_holdclr) else $error("hold left alone");
  property p_holdhs;
    $rose(arm_hold) |-> $past(high_speed);
  endproperty
  a_holdhs: assert property (p_holdhs) else $error("hold outside high speed");
  property p_quiet;
    disable iff (1'h0) !rst_n |=> !out_valid && !arm_hold && !arm_error;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
  c_out: cover property (out_valid);
  c_hold: cover property ($rose(arm_hold));
  c_err: cover property (arm_error);
endmodule

bind rdmem_store rdmem_store_properties rdmem_store_properties_i (
  .clk(clk), .rst_n(rst_n), .arm_event(arm_event), .subsampled(subsampled),
  .arm_source_set(arm_source_set), .high_speed(high_speed), .data_request(data_request),
  .out_buf_empty(out_buf_empty), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .arm_hold(arm_hold), .arm_error(arm_error), .out_valid(out_valid), .out_data(out_data));

// file: test/rdmem_engine.sv
// Measurement engine model: hands completed readings to the store.
// Assumes put is called from the bench right after a rising edge.
`timescale 1ns/1ns
module rdmem_engine (
  input  wire logic   clk,
  output logic        rdg_valid,
  output logic [63:0] rdg_value,
  output logic        rdg_ovld,
  output logic        rdg_ovld_neg
);
  initial begin
    rdg_valid = 1'h0;
    rdg_value = 64'h0;
    rdg_ovld = 1'h0;
    rdg_ovld_neg = 1'h0;
  end
  // Value scrambled after the strobe so a stale reading never looks fresh
  task automatic put(input logic [63:0] v);
    @(posedge clk);
    rdg_valid <= 1'h1;
    rdg_value <= v;
    @(posedge clk);
    rdg_valid <= 1'h0;
    rdg_value <= ~v;
  endtask
  // Overload reading of the given sign
  task automatic put_ovld(input logic neg);
    @(posedge clk);
    rdg_valid <= 1'h1;
    rdg_ovld <= 1'h1;
    rdg_ovld_neg <= neg;
    @(posedge clk);
    rdg_valid <= 1'h0;
    rdg_ovld <= 1'h0;
    rdg_ovld_neg <= 1'h0;
  endtask
endmodule

// file: test/rdmem_store_bench.sv
// Bench for the reading memory store: bus tasks and directed sequences.
// Assumes rdmem_regs.svh codes and the engine model beside it.
`timescale 1ns/1ns
`include "rdmem_regs.svh"
module rdmem_store_bench;
  logic        clk = 1'h0, rst_n = 1'h0, high_speed = 1'h0, arm_event = 1'h0;
  logic        subsampled = 1'h0, arm_source_set = 1'h0, data_request = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic        rready = 1'h0, awready, wready, bvalid, arready, rvalid;
  logic        obe = 1'h1;
  logic [3:0]  wstrb = 4'hF;
  logic        out_valid, arm_hold, arm_error, rdg_valid, rdg_ovld, rdg_ovld_neg;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [1:0]  bresp, rresp, rs;
  logic [63:0] rdg_value, out_data;
  int          n_mismatch = 0, compares = 0;
  always #10 clk = ~clk;
  rdmem_engine rdmem_engine_i (.clk(clk), .rdg_valid(rdg_valid), .rdg_value(rdg_value),
    .rdg_ovld(rdg_ovld), .rdg_ovld_neg(rdg_ovld_neg));
  rdmem_store #(.DEPTH(8), .AW(3)) rdmem_store_i (.clk(clk), .rst_n(rst_n),
    .rdg_valid(rdg_valid), .rdg_value(rdg_value), .rdg_ovld(rdg_ovld),
    .rdg_ovld_neg(rdg_ovld_neg), .high_speed(high_speed), .arm_event(arm_event),
    .subsampled(subsampled), .arm_source_set(arm_source_set), .out_buf_empty(obe),
    .data_request(data_request), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .arm_hold(arm_hold), .arm_error(arm_error), .out_valid(out_valid), .out_data(out_data));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid && n < 40);
    if (!bvalid) n_mismatch++;
    bready <= 1'h0;
    rs = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'h0;
    end while (!rvalid && n < 40);
    if (!rvalid) n_mismatch++;
    rready <= 1'h0;
    rv = rdata;
    rs = rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, rv, e);
  endtask
  // Implied read: one request pulse, then the answer strobe
  task automatic imp(input logic [63:0] e);
    int n;
    n = 0;
    @(posedge clk);
    data_request <= 1'h1;
    @(posedge clk);
    data_request <= 1'h0;
    do begin
      @(posedge clk);
      n++;
    end while (!out_valid && n < 8);
    chk("reading", out_data, e);
  endtask
  task automatic arm(input logic e);
    @(posedge clk);
    arm_event <= 1'h1;
    subsampled <= 1'h1;
    @(posedge clk);
    arm_event <= 1'h0;
    @(posedge clk);
    chk("arm_error", arm_error, e);
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rc(`RDMEM_CTRL_OFF, 32'h0, "mode");
    rc(`RDMEM_FORMAT_OFF, 32'h4, "format");
    rdmem_engine_i.put(64'h9);
    rc(`RDMEM_COUNT_OFF, 32'h0, "count");
    wr(`RDMEM_CTRL_OFF, `RDMEM_MODE_FIFO);
    for (int i = 1; i <= 3; i++) rdmem_engine_i.put(64'(i));
    rc(`RDMEM_COUNT_OFF, 32'h3, "count");
    imp(32'h1);
    wr(`RDMEM_CTRL_OFF, `RDMEM_MODE_OFF);
    rdmem_engine_i.put(64'h7);
    rc(`RDMEM_COUNT_OFF, 32'h2, "count");
    wr(`RDMEM_CTRL_OFF, `RDMEM_MODE_RESUME);
    rc(`RDMEM_CTRL_OFF, 32'h2, "mode");
    imp(32'h2);
    wr(`RDMEM_CTRL_OFF, `RDMEM_MODE_LIFO);
    rc(`RDMEM_COUNT_OFF, 32'h0, "count");
    for (int i = 4; i <= 6; i++) rdmem_engine_i.put(64'(i));
    imp(32'h6);
    wr(`RDMEM_COUNT_OFF, 32'h2);
    rdmem_engine_i.put(64'h8);
    rc(`RDMEM_COUNT_OFF, 32'h2, "count");
    imp(32'h8);
    imp(32'h5);
    wr(`RDMEM_CTRL_OFF, `RDMEM_MODE_FIFO);
    for (int i = 1; i <= 3; i++) rdmem_engine_i.put(64'(i));
    rc(`RDMEM_STATUS_OFF, 32'h5, "status");
    imp(32'h1);
    high_speed <= 1'h1;
    wr(`RDMEM_CTRL_OFF, `RDMEM_MODE_FIFO);
    for (int i = 1; i <= 2; i++) rdmem_engine_i.put(64'(i));
    repeat (2) @(posedge clk);
    chk("arm_hold", arm_hold, 1'h1);
    high_speed <= 1'h0;
    arm_source_set <= 1'h1;
    @(posedge clk);
    arm_source_set <= 1'h0;
    @(posedge clk);
    chk("arm_hold", arm_hold, 1'h0);
    wr(`RDMEM_CTRL_OFF, `RDMEM_MODE_LIFO);
    rdmem_engine_i.put(64'hA);
    rdmem_engine_i.put(64'hB);
    wr(`RDMEM_RECALL_OFF, 32'h0);
    rc(`RDMEM_DATA_LO_OFF, 32'hA, "recalled");
    rc(`RDMEM_CTRL_OFF, 32'h0, "mode");
    rdmem_engine_i.put(64'hC);
    rc(`RDMEM_COUNT_OFF, 32'h2, "count");
    for (int f = 1; f <= 5; f++) begin
      wr(`RDMEM_CTRL_OFF, `RDMEM_MODE_FIFO);
      rdmem_engine_i.put(64'h3);
      wr(`RDMEM_FORMAT_OFF, 32'(f));
      rc(`RDMEM_COUNT_OFF, 32'h0, "count");
      rc(`RDMEM_FORMAT_OFF, 32'(f), "format");
    end
    wr(`RDMEM_FORMAT_OFF, 32'h1);
    wr(`RDMEM_RECALL_OFF, 32'h0);
    rc(`RDMEM_RECALL_OFF, 32'h10, "text_len");
    wr(8'h40, 32'h1);
    chk("bresp", rs, 2'h2);
    rc(8'h44, 32'h0, "unmapped");
    chk("rresp", rs, 2'h2);
    arm(1'h1);
    wr(`RDMEM_FORMAT_OFF, `RDMEM_FMT_INT16);
    wr(`RDMEM_CTRL_OFF, `RDMEM_MODE_FIFO);
    arm(1'h0);
    wr(`RDMEM_CTRL_OFF, `RDMEM_MODE_LIFO);
    arm(1'h1);
    wr(`RDMEM_FORMAT_OFF, `RDMEM_FMT_FLOAT32);
    wr(`RDMEM_CTRL_OFF, `RDMEM_MODE_FIFO);
    rdmem_engine_i.put_ovld(1'h0);
    rdmem_engine_i.put_ovld(1'h1);
    imp(`RDMEM_OVLD_POS);
    obe <= 1'h0;
    @(posedge clk);
    data_request <= 1'h1;
    @(posedge clk);
    data_request <= 1'h0;
    @(posedge clk);
    chk("out_valid", out_valid, 1'h0);
    obe <= 1'h1;
    rc(`RDMEM_COUNT_OFF, 32'h1, "count");
    imp(`RDMEM_OVLD_NEG);
    wstrb <= 4'h0;
    wr(`RDMEM_CTRL_OFF, `RDMEM_MODE_OFF);
    wstrb <= 4'hF;
    rc(`RDMEM_CTRL_OFF, 32'h2, "mode");
    finish_test();
  end
endmodule
